// ===== hdl/bcd_step.sv
`timescale 1ns/1ns
`default_nettype none

// two-digit packed bcd increment with wrap to a first value
module bcd_step (
    input wire logic [7:0] value,  // current packed bcd value
    input wire logic [7:0] last,   // highest legal value
    input wire logic [7:0] first,  // value after wrap
    output logic [7:0] next,       // incremented value
    output logic wrap              // value was at or beyond last
);
    import rtc_cal_pkg::*;

    logic [3:0] units;
    logic [3:0] tens;
    logic [3:0] units_inc;
    logic [3:0] tens_inc;
    logic units_carry;

    assign units = value[UNITS_HI:UNITS_LO];
    assign tens = value[YEAR_TENS_HI:YEAR_TENS_LO];
    assign units_carry = (units >= BCD_NINE);
    assign units_inc = units + 4'h1;
    assign tens_inc = tens + 4'h1;
    // a value written out of range also wraps, so a bad write cannot run away
    assign wrap = (value >= last);
    assign next = wrap ? first :
                  units_carry ? {tens_inc, BCD_ZERO} : {tens, units_inc};

endmodule

`default_nettype wire

// ===== hdl/leap_detect.sv
`timescale 1ns/1ns
`default_nettype none

// two-digit bcd year divisible by four
module leap_detect (
    input wire logic [7:0] year,  // packed bcd year
    output logic leap             // year is a multiple of four
);
    import rtc_cal_pkg::*;

    // (10t + u) mod 4 == (2t + u) mod 4, so only tens lsb and units low bits count
    assign leap = (year[UNITS_LO + 1:UNITS_LO] == {year[YEAR_TENS_LO], 1'b0});

endmodule

`default_nettype wire

// ===== hdl/rtc_cal_pkg.sv
package rtc_cal_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses on the register port
    localparam logic [7:0] ADDR_DAY = 8'h04;
    localparam logic [7:0] ADDR_MONTH = 8'h05;
    localparam logic [7:0] ADDR_YEAR = 8'h06;

    // power-on values
    localparam logic [7:0] RESET_DAY = 8'h01;
    localparam logic [7:0] RESET_MONTH = 8'h01;
    localparam logic [7:0] RESET_YEAR = 8'h01;
    localparam logic RESET_LEAP = 1'b0;
    localparam logic [7:0] RESET_RDATA = 8'h00;

    // writable bits per register
    localparam logic [7:0] DAY_WR_MASK = 8'h3F;
    localparam logic [7:0] MONTH_WR_MASK = 8'h1F;
    localparam logic [7:0] YEAR_WR_MASK = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int UNUSED_HI = 7;
    localparam int UNUSED_LO = 6;
    localparam int DAY_TENS_HI = 5;
    localparam int DAY_TENS_LO = 4;
    localparam int LEAP_BIT = 5;
    localparam int MONTH_TENS_BIT = 4;
    localparam int UNITS_HI = 3;
    localparam int UNITS_LO = 0;
    localparam int YEAR_TENS_HI = 7;
    localparam int YEAR_TENS_LO = 4;

    ////////////////////////////////////////////////////////////////////////////
    // calendar limits, packed bcd
    localparam logic [3:0] BCD_NINE = 4'h9;
    localparam logic [3:0] BCD_ZERO = 4'h0;
    localparam logic [7:0] FIRST_DAY = 8'h01;
    localparam logic [7:0] FIRST_MONTH = 8'h01;
    localparam logic [7:0] FIRST_YEAR = 8'h00;
    localparam logic [7:0] LAST_MONTH = 8'h12;
    localparam logic [7:0] LAST_YEAR = 8'h99;
    localparam logic [7:0] MONTH_FEB = 8'h02;
    localparam logic [7:0] MONTH_APR = 8'h04;
    localparam logic [7:0] MONTH_JUN = 8'h06;
    localparam logic [7:0] MONTH_SEP = 8'h09;
    localparam logic [7:0] MONTH_NOV = 8'h11;
    localparam logic [7:0] DAYS_FEB = 8'h28;
    localparam logic [7:0] DAYS_FEB_LEAP = 8'h29;
    localparam logic [7:0] DAYS_SHORT = 8'h30;
    localparam logic [7:0] DAYS_LONG = 8'h31;

endpackage

// ===== hdl/rtc_calendar_date_regs.sv
`timescale 1ns/1ns
`default_nettype none

module rtc_calendar_date_regs (
    input wire logic clk_sys,                 // system clock, 25 MHz
    input wire logic rstn,                    // async reset, active low
    input wire logic [7:0] reg_addr,          // register byte address
    input wire logic reg_wr,                  // write strobe, one cycle
    input wire logic [7:0] reg_wdata,         // write data
    input wire logic reg_rd,                  // read strobe, one cycle
    input wire logic day_tick,                // advance one day, one cycle
    output logic [7:0] reg_rdata,             // read data, valid after reg_rd
    output logic leap_year_flag               // current year is a leap year
);
    import rtc_cal_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] day_q;
    logic [7:0] day_d;
    logic [7:0] month_q;
    logic [7:0] month_d;
    logic [7:0] year_q;
    logic [7:0] year_d;
    logic leap_q;
    logic leap_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    logic sel_day;
    logic sel_month;
    logic sel_year;
    logic wr_day;
    logic wr_month;
    logic wr_year;
    logic any_wr;
    logic advance;

    assign sel_day = (reg_addr == ADDR_DAY);
    assign sel_month = (reg_addr == ADDR_MONTH);
    assign sel_year = (reg_addr == ADDR_YEAR);
    assign wr_day = reg_wr && sel_day;
    assign wr_month = reg_wr && sel_month;
    assign wr_year = reg_wr && sel_year;
    assign any_wr = wr_day || wr_month || wr_year;
    // a host write drops a coincident tick so the written date is never half-advanced
    assign advance = day_tick && !any_wr;

    ////////////////////////////////////////////////////////////////////////////
    // calendar advance
    logic [7:0] last_day;
    logic [7:0] day_next;
    logic [7:0] month_next;
    logic [7:0] year_next;
    logic day_wrap;
    logic month_wrap;
    logic month_is_feb;
    logic month_is_short;

    assign month_is_feb = (month_q == MONTH_FEB);
    assign month_is_short = (month_q == MONTH_APR) || (month_q == MONTH_JUN) ||
                            (month_q == MONTH_SEP) || (month_q == MONTH_NOV);
    assign last_day = month_is_feb ? (leap_q ? DAYS_FEB_LEAP : DAYS_FEB) :
                      month_is_short ? DAYS_SHORT : DAYS_LONG;

    bcd_step u_day_step (
        .value(day_q),
        .last(last_day),
        .first(FIRST_DAY),
        .next(day_next),
        .wrap(day_wrap)
    );

    bcd_step u_month_step (
        .value(month_q),
        .last(LAST_MONTH),
        .first(FIRST_MONTH),
        .next(month_next),
        .wrap(month_wrap)
    );

    bcd_step u_year_step (
        .value(year_q),
        .last(LAST_YEAR),
        .first(FIRST_YEAR),
        .next(year_next),
        .wrap()
    );

    leap_detect u_leap (
        .year(year_q),
        .leap(leap_d)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next-state selection
    logic month_roll;
    logic year_roll;

    assign month_roll = advance && day_wrap;
    assign year_roll = month_roll && month_wrap;

    // unimplemented bits are masked off at the write so they always read zero
    assign day_d = wr_day ? (reg_wdata & DAY_WR_MASK) :
                   advance ? day_next : day_q;
    // leap bit is not in the month write mask, host cannot touch it
    assign month_d = wr_month ? (reg_wdata & MONTH_WR_MASK) :
                     month_roll ? month_next : month_q;
    assign year_d = wr_year ? (reg_wdata & YEAR_WR_MASK) :
                    year_roll ? year_next : year_q;

    ////////////////////////////////////////////////////////////////////////////
    // read mux
    logic [7:0] rd_day;
    logic [7:0] rd_month;
    logic [7:0] rd_year;

    assign rd_day = {2'b00, day_q[DAY_TENS_HI:UNITS_LO]};
    assign rd_month = {2'b00, leap_q, month_q[MONTH_TENS_BIT:UNITS_LO]};
    assign rd_year = year_q;
    // unmapped addresses read zero
    assign rdata_d = !reg_rd ? rdata_q :
                     sel_day ? rd_day :
                     sel_month ? rd_month :
                     sel_year ? rd_year : RESET_RDATA;

    ////////////////////////////////////////////////////////////////////////////
    // flops
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            day_q <= RESET_DAY;
            month_q <= RESET_MONTH;
            year_q <= RESET_YEAR;
        end else begin
            day_q <= day_d;
            month_q <= month_d;
            year_q <= year_d;
        end
    end

    // leap flag lags the year by one clock; cheap and harmless at day rate
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            leap_q <= RESET_LEAP;
        end else begin
            leap_q <= leap_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= RESET_RDATA;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign leap_year_flag = leap_q;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    property p_unused_zero;
        (reg_rd && (sel_day || sel_month)) |=> (reg_rdata[UNUSED_HI:UNUSED_LO] == 2'b00);
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unimplemented date or month bits read nonzero");

    property p_day_tens_write;
        wr_day |=> (day_q[DAY_TENS_HI:DAY_TENS_LO] == $past(reg_wdata[DAY_TENS_HI:DAY_TENS_LO]));
    endproperty
    a_day_tens_write: assert property (p_day_tens_write)
        else $error("day tens digit not stored from write");

    property p_day_units_readback;
        wr_day ##1 (!wr_day && !day_tick) ##1 (reg_rd && sel_day && !reg_wr) |=>
            (reg_rdata[UNITS_HI:UNITS_LO] == $past(reg_wdata[UNITS_HI:UNITS_LO], 3));
    endproperty
    a_day_units_readback: assert property (p_day_units_readback)
        else $error("day units digit readback mismatch");

    property p_leap_read_only;
        wr_month && !wr_year && $stable(year_q) |=>
            (leap_q == $past(leap_q)) && !month_q[LEAP_BIT];
    endproperty
    a_leap_read_only: assert property (p_leap_read_only)
        else $error("month write disturbed leap flag");

    property p_leap_readback;
        (reg_rd && sel_month) |=> (reg_rdata[LEAP_BIT] == $past(leap_q));
    endproperty
    a_leap_readback: assert property (p_leap_readback)
        else $error("leap bit in month read does not match flag");

    property p_month_tens_write;
        wr_month |=> (month_q[MONTH_TENS_BIT] == $past(reg_wdata[MONTH_TENS_BIT]))
            && (month_q[LEAP_BIT] == 1'b0);
    endproperty
    a_month_tens_write: assert property (p_month_tens_write)
        else $error("month tens bit not stored from write");

    property p_month_units_write;
        wr_month |=> (month_q[UNITS_HI:UNITS_LO] == $past(reg_wdata[UNITS_HI:UNITS_LO]));
    endproperty
    a_month_units_write: assert property (p_month_units_write)
        else $error("month units digit not stored from write");

    property p_year_tens_readback;
        wr_year ##1 (!wr_year && !day_tick) ##1 (reg_rd && sel_year && !reg_wr) |=>
            (reg_rdata[YEAR_TENS_HI:YEAR_TENS_LO] == $past(reg_wdata[YEAR_TENS_HI:YEAR_TENS_LO], 3));
    endproperty
    a_year_tens_readback: assert property (p_year_tens_readback)
        else $error("year tens digit readback mismatch");

    property p_year_units_write;
        wr_year |=> (year_q[UNITS_HI:UNITS_LO] == $past(reg_wdata[UNITS_HI:UNITS_LO]));
    endproperty
    a_year_units_write: assert property (p_year_units_write)
        else $error("year units digit not stored from write");

    property p_leap_set;
        (wr_year && reg_wdata == 8'h24) ##1 !wr_year |=> leap_q;
    endproperty
    a_leap_set: assert property (p_leap_set)
        else $error("leap flag not set two cycles after year 24 write");

    property p_leap_clear;
        (wr_year && reg_wdata == 8'h26) ##1 !wr_year |=> !leap_q;
    endproperty
    a_leap_clear: assert property (p_leap_clear)
        else $error("leap flag set for year 26");

    property p_day_rollover;
        (advance && day_wrap) |=> (day_q == FIRST_DAY);
    endproperty
    a_day_rollover: assert property (p_day_rollover)
        else $error("day did not wrap to first day");

    // a tick that meets a write is dropped whole, so the date cannot half-advance
    property p_write_drops_tick;
        (day_tick && (wr_month || wr_year)) |=> (day_q == $past(day_q));
    endproperty
    a_write_drops_tick: assert property (p_write_drops_tick)
        else $error("day advanced on a tick that met a write");

    property p_unmapped_read_zero;
        (reg_rd && !sel_day && !sel_month && !sel_year) |=> (reg_rdata == RESET_RDATA);
    endproperty
    a_unmapped_read_zero: assert property (p_unmapped_read_zero)
        else $error("read of an unmapped address returned nonzero");

    // read data must stand between reads; a host may sample it late
    property p_rdata_holds;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rdata_holds: assert property (p_rdata_holds)
        else $error("read data changed without a read");

    property p_month_quiet;
        (advance && !day_wrap) |=> $stable(month_q) && $stable(year_q);
    endproperty
    a_month_quiet: assert property (p_month_quiet)
        else $error("month or year moved on a mid-month tick");

    property p_month_wrap;
        year_roll |=> (month_q == FIRST_MONTH);
    endproperty
    a_month_wrap: assert property (p_month_wrap)
        else $error("month did not wrap to first month at year end");

    property p_year_wrap;
        (year_roll && (year_q == LAST_YEAR)) |=> (year_q == FIRST_YEAR);
    endproperty
    a_year_wrap: assert property (p_year_wrap)
        else $error("year did not wrap to first year after last");

    property p_leap_year_zero;
        $stable(year_q) && (year_q == FIRST_YEAR) |=> leap_q;
    endproperty
    a_leap_year_zero: assert property (p_leap_year_zero)
        else $error("leap flag low for year zero");

    c_month_end: cover property (advance && day_wrap && !month_wrap);
    c_year_end: cover property (year_roll && year_q == LAST_YEAR);
    c_feb_leap: cover property (advance && month_is_feb && leap_q && day_q == DAYS_FEB_LEAP);
    c_write_beats_tick: cover property (day_tick && any_wr);
    c_unmapped_read: cover property (reg_rd && !sel_day && !sel_month && !sel_year);

endmodule

`default_nettype wire

// ===== test/rtc_calendar_date_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end

module rtc_calendar_date_regs_tb_top;
    import rtc_cal_pkg::*;
    logic clk_sys, rstn, reg_wr, reg_rd, day_tick, leap_year_flag, rd_pend;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, y, m, d, exp_v;
    logic [7:0] q[$];
    logic [47:0] tk[7];
    int errors = 0;
    int n_compared = 0;

    rtc_calendar_date_regs dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .day_tick(day_tick),
        .reg_rdata(reg_rdata), .leap_year_flag(leap_year_flag));
    rtc_host host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .day_tick(day_tick));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    function automatic logic lp(input logic [7:0] v);
        return ((int'(v[7:4]) * 10 + int'(v[3:0])) % 4) == 0;
    endfunction

    function automatic logic [7:0] rbcd(input int tens_max);
        return {4'($urandom % tens_max), 4'($urandom % 10)};
    endfunction

    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        host.rd(a);
    endtask

    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // read data lands on the taking edge and is checked on the falling edge after it
    always @(posedge clk_sys) rd_pend <= reg_rd;
    always @(negedge clk_sys) begin
        if (rd_pend === 1'b1) begin
            if (q.size() == 0) begin
                errors++;
                $display("ERROR t=%0t got %h exp %h", $time, reg_rdata, 8'h00);
            end else begin
                exp_v = q.pop_front();
                `CHK(reg_rdata, exp_v)
            end
        end
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        // {date, month, year} before a tick and after it
        tk = '{48'h311223_010124, 48'h280223_010323, 48'h280224_290224,
               48'h300424_010524, 48'h310199_010299, 48'h311299_010100,
               48'h290224_010324};
        void'($urandom(59650));
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        `CHK(leap_year_flag, RESET_LEAP)
        rd_exp(ADDR_DAY, RESET_DAY);
        rd_exp(ADDR_MONTH, RESET_MONTH);
        rd_exp(ADDR_YEAR, RESET_YEAR);
        rd_exp(8'h07, 8'h00);
        for (int i = 0; i < 8; i++) begin
            d = rbcd(4);
            host.wr(ADDR_DAY, {2'($urandom), d[5:0]});
            rd_exp(ADDR_DAY, d);
            y = rbcd(10);
            host.wr(ADDR_YEAR, y);
            rd_exp(ADDR_YEAR, y);
            m = {3'($urandom), 1'($urandom), 4'($urandom % 10)};
            host.wr(ADDR_MONTH, m);
            `CHK(leap_year_flag, lp(y))
            rd_exp(ADDR_MONTH, {2'b00, lp(y), m[4:0]});
        end
        // a leap year with the flag bit written low must still read one
        host.wr(ADDR_YEAR, 8'h96);
        host.wr(ADDR_MONTH, 8'h09);
        rd_exp(ADDR_MONTH, 8'h29);
        host.wr(ADDR_YEAR, 8'h26);
        rd_exp(ADDR_MONTH, 8'h09);
        foreach (tk[i]) begin
            host.wr(ADDR_DAY, tk[i][47:40]);
            host.wr(ADDR_MONTH, tk[i][39:32]);
            host.wr(ADDR_YEAR, tk[i][31:24]);
            host.tick();
            rd_exp(ADDR_DAY, tk[i][23:16]);
            rd_exp(ADDR_MONTH, {2'b00, lp(tk[i][7:0]), tk[i][12:8]});
            rd_exp(ADDR_YEAR, tk[i][7:0]);
            `CHK(leap_year_flag, lp(tk[i][7:0]))
        end
        // a month write that meets a tick wins and the tick is lost
        fork
            host.wr(ADDR_MONTH, 8'h07);
            host.tick();
        join
        rd_exp(ADDR_DAY, 8'h01);
        rd_exp(ADDR_MONTH, 8'h27);
        repeat (3) @(negedge clk_sys);
        if (q.size() != 0)
            errors++;
        close_out();
    end
endmodule

`default_nettype wire

// ===== test/rtc_host.sv
`timescale 1ns/1ns
`default_nettype none

// host side of the register port; changes its requests on the falling edge
module rtc_host (
    input wire logic clk_sys,        // system clock
    output logic [7:0] reg_addr,     // register address
    output logic reg_wr,             // write strobe
    output logic [7:0] reg_wdata,    // write data
    output logic reg_rd,             // read strobe
    output logic day_tick            // one-day advance
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        day_tick = 1'b0;
    end

    // idle bus shows inverted last values, so a stale sample cannot match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask

    task automatic tick();
        @(negedge clk_sys);
        day_tick = 1'b1;
        @(negedge clk_sys);
        day_tick = 1'b0;
    endtask
endmodule

`default_nettype wire
